// >>> bfpl_pkg.sv
package bfpl_pkg;

    // ********************************************************************
    // Clock and time base
    // ********************************************************************
    localparam int CLK_HZ          = 25_000_000;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PULSE_MIN_MS    = 20;
    localparam int PULSE_MAX_MS    = 15000;
    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_T_SP    = 8'h04;
    localparam logic [7:0] REG_T_MP    = 8'h08;
    localparam logic [7:0] REG_T_PLS   = 8'h0C;
    localparam logic [7:0] REG_T_CBF   = 8'h10;
    localparam logic [7:0] REG_T_REP   = 8'h14;
    localparam logic [7:0] REG_T_REL   = 8'h18;
    localparam logic [7:0] REG_STATUS  = 8'h1C;
    localparam logic [7:0] REG_ALARM   = 8'h20;

    // CTRL fields
    localparam int CTRL_OPM_LSB    = 0;
    localparam int CTRL_ISS_LSB    = 4;
    localparam int CTRL_LOWI_BIT   = 6;

    // Reset values of timing settings (ms)
    localparam logic [15:0] RST_T_SP  = 16'h0064;
    localparam logic [15:0] RST_T_MP  = 16'h0064;
    localparam logic [15:0] RST_T_PLS = 16'h0064;
    localparam logic [15:0] RST_T_CBF = 16'h0032;
    localparam logic [15:0] RST_T_REP = 16'h0032;
    localparam logic [15:0] RST_T_REL = 16'h01F4;

    // ********************************************************************
    // Modes and states
    // ********************************************************************
    typedef enum logic [2:0] {
        OPM_DISABLED   = 3'b000,
        OPM_CUR_CHECK  = 3'b001,
        OPM_REP_CUR    = 3'b010,
        OPM_UNBAL      = 3'b011,
        OPM_REP_UNBAL  = 3'b100,
        OPM_EXTERNAL   = 3'b101
    } bfpl_opm_t;

    typedef enum logic [1:0] {
        ISS_1CH_NOSUP  = 2'b00,
        ISS_1CH_SUP    = 2'b01,
        ISS_2CH_NOSUP  = 2'b10,
        ISS_2CH_SUP    = 2'b11
    } bfpl_iss_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STAGE1 = 2'b01,
        ST_STAGE2 = 2'b10,
        ST_TRIP   = 2'b11
    } bfpl_st_t;

endpackage

// >>> bfpl_core.sv
// Behaviour
// RULE1: pulse start only in repeat modes
// RULE2: independent remote pulse start
// RULE3: remote pulse lasts 20 ms to 15 s
// RULE4: pulse fault raises bay, group alarm
// RULE5: pulse delay plus current gives feeder trip
// RULE6: still current after delay trips bus zone
// RULE7: busbar trip starts internal supervision
// RULE8: lasting current gives transfer trip
// RULE9: busbar breaker failure raises transfer alarms
// RULE10: remote equipment trips after multi-pole delay
// RULE11: coupler closed fault trips zone and coupler
// RULE12: persistent coupler current inverts its polarity
// RULE13: unbalanced coupler current trips healthy zone
// RULE14: breaker not ready selects breaker fault delay
// RULE15: not ready blocks repeat unless low-current
// RULE16: each trip also transfer trips; repeat_trip_o does not drive transfer_trip_o
// RULE17: four initiation supervision settings
// RULE18: six operating modes, each only its own
// RULE19: unsupervised initiation only for testing
// RULE20: pulse delay times pulse-mode repetition
// RULE21: timers reset when conditions drop out
`timescale 1ns/100ps
module bfpl_core
    import bfpl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input  wire logic        ref_clk_i,           // 25 MHz clock
    input  wire logic        rst_i,               // Sync reset, high
    input  wire logic [7:0]  addr_i,              // Register address
    input  wire logic [31:0] wdata_i,             // Write data
    input  wire logic        wr_i,                // Write strobe
    input  wire logic        rd_i,                // Read strobe
    output logic      [31:0] rdata_o,             // Read data
    input  wire logic        feeder_init_i,       // Feeder start pin
    input  wire logic        multi_pole_i,        // Start is multi-pole
    input  wire logic        release_i,           // Release pin
    input  wire logic        remote_pulse_i,      // Remote pulse pin
    input  wire logic        remote_pulse_alloc_i,// Pulse input allocated
    input  wire logic        breaker_not_ready_i, // Not-ready pin
    input  wire logic        current_release_i,   // Current over threshold
    input  wire logic        sens_current_i,      // Over sensitive thresh.
    input  wire logic        busbar_trip_i,       // Busbar trip command
    input  wire logic        coupler_bay_i,       // Bay is a coupler
    output logic             repeat_trip_o,       // Feeder repeat trip
    output logic             bus_zone_trip_o,     // Own zone trip
    output logic             healthy_zone_trip_o, // Coupler other zone
    output logic             transfer_trip_o,     // To remote end
    output logic             invert_polarity_o,   // Coupler unbalance
    output logic             pulse_duration_alarm_o,   // Per-bay alarm
    output logic             pulse_duration_group_o,   // Group alarm
    output logic             transfer_trip_alarm_o,    // Per-bay alarm
    output logic             transfer_trip_group_o     // Group alarm
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    logic [6:0] sy1_r, sy2_r, sy1_nxt;
    logic init_s, rel_s, pls_s, bnr_s, cur_s, sen_s, mp_s;

    always_comb
    begin
        sy1_nxt = {multi_pole_i, sens_current_i, current_release_i,
                   breaker_not_ready_i, remote_pulse_i, release_i,
                   feeder_init_i};
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sy1_r <= 7'h00;
            sy2_r <= 7'h00;
        end
        else
        begin
            sy1_r <= sy1_nxt;
            sy2_r <= sy1_r;
        end
    end

    assign {mp_s, sen_s, cur_s, bnr_s, pls_s, rel_s, init_s} = sy2_r;

    // ********************************************************************
    // Settings registers
    // ********************************************************************
    logic [2:0]  opm_r, opm_nxt;
    logic [1:0]  iss_r, iss_nxt;
    logic        lowi_r, lowi_nxt;
    logic [15:0] t_sp_r, t_mp_r, t_pls_r, t_cbf_r, t_rep_r, t_rel_r;
    logic [15:0] t_sp_nxt, t_mp_nxt, t_pls_nxt, t_cbf_nxt;
    logic [15:0] t_rep_nxt, t_rel_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0]  alarm_r;
    logic [1:0]  st_bits;

    // Decode writes, latch read data
    always_comb
    begin
        opm_nxt   = opm_r;
        iss_nxt   = iss_r;
        lowi_nxt  = lowi_r;
        t_sp_nxt  = t_sp_r;
        t_mp_nxt  = t_mp_r;
        t_pls_nxt = t_pls_r;
        t_cbf_nxt = t_cbf_r;
        t_rep_nxt = t_rep_r;
        t_rel_nxt = t_rel_r;
        rdata_nxt = 32'h0000_0000;
        if (wr_i)
        begin
            unique case (addr_i)
                REG_CTRL:
                begin
                    // RULE18: mode select
                    opm_nxt  = wdata_i[CTRL_OPM_LSB +: 3];
                    // RULE17: supervision select
                    iss_nxt  = wdata_i[CTRL_ISS_LSB +: 2];
                    lowi_nxt = wdata_i[CTRL_LOWI_BIT];
                end
                REG_T_SP:  t_sp_nxt  = wdata_i[15:0];
                REG_T_MP:  t_mp_nxt  = wdata_i[15:0];
                REG_T_PLS: t_pls_nxt = wdata_i[15:0];
                REG_T_CBF: t_cbf_nxt = wdata_i[15:0];
                REG_T_REP: t_rep_nxt = wdata_i[15:0];
                REG_T_REL: t_rel_nxt = wdata_i[15:0];
                default:   ;
            endcase
        end
        if (rd_i)
        begin
            unique case (addr_i)
                REG_CTRL:   rdata_nxt = {25'h0, lowi_r, iss_r, 1'b0, opm_r};
                REG_T_SP:   rdata_nxt = {16'h0, t_sp_r};
                REG_T_MP:   rdata_nxt = {16'h0, t_mp_r};
                REG_T_PLS:  rdata_nxt = {16'h0, t_pls_r};
                REG_T_CBF:  rdata_nxt = {16'h0, t_cbf_r};
                REG_T_REP:  rdata_nxt = {16'h0, t_rep_r};
                REG_T_REL:  rdata_nxt = {16'h0, t_rel_r};
                REG_STATUS: rdata_nxt = {24'h0, invert_polarity_o,
                                         transfer_trip_o, healthy_zone_trip_o,
                                         bus_zone_trip_o, repeat_trip_o,
                                         1'b0, st_bits};
                REG_ALARM:  rdata_nxt = {28'h0, alarm_r};
                default:    ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            opm_r   <= 3'h0;
            iss_r   <= 2'h3;
            lowi_r  <= 1'b0;
            t_sp_r  <= RST_T_SP;
            t_mp_r  <= RST_T_MP;
            t_pls_r <= RST_T_PLS;
            t_cbf_r <= RST_T_CBF;
            t_rep_r <= RST_T_REP;
            t_rel_r <= RST_T_REL;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            opm_r   <= opm_nxt;
            iss_r   <= iss_nxt;
            lowi_r  <= lowi_nxt;
            t_sp_r  <= t_sp_nxt;
            t_mp_r  <= t_mp_nxt;
            t_pls_r <= t_pls_nxt;
            t_cbf_r <= t_cbf_nxt;
            t_rep_r <= t_rep_nxt;
            t_rel_r <= t_rel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // ********************************************************************
    // Millisecond tick divider
    // ********************************************************************
    logic [15:0] div_r, div_nxt;
    logic        tick;

    assign tick = (div_r == 16'(TICK_CYCLES - 1));

    always_comb
    begin
        div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            div_r <= 16'h0000;
        else
            div_r <= div_nxt;
    end

    // ********************************************************************
    // Initiation qualification
    // ********************************************************************
    logic sup_on, two_ch, mode_rep, mode_unb, mode_ext, mode_on;
    logic start_raw, start_ok, pls_ok, sup_fail;

    assign sup_on   = iss_r[0];
    assign two_ch   = iss_r[1];
    assign mode_rep = (opm_r == OPM_REP_CUR) || (opm_r == OPM_REP_UNBAL);
    assign mode_unb = (opm_r == OPM_UNBAL) || (opm_r == OPM_REP_UNBAL);
    assign mode_ext = (opm_r == OPM_EXTERNAL);
    assign mode_on  = (opm_r != OPM_DISABLED) && (opm_r <= OPM_EXTERNAL);

    // RULE17: two-channel needs release
    assign start_raw = init_s && (!two_ch || rel_s);
    assign start_ok  = start_raw && mode_on && !sup_fail;
    // RULE1: pulse only in repeat modes
    // RULE2: independent allocated pulse start
    assign pls_ok = remote_pulse_alloc_i && pls_s && mode_rep;

    // ********************************************************************
    // Release and pulse duration supervision
    // ********************************************************************
    logic [15:0] sup_ms_r, sup_ms_nxt, pls_ms_r, pls_ms_nxt;
    logic        sup_fail_r, sup_fail_nxt, pls_al_r, pls_al_nxt;
    logic        pls_d_r;

    always_comb
    begin
        sup_ms_nxt   = start_raw ? sup_ms_r : 16'h0000;
        sup_fail_nxt = sup_fail_r && start_raw;
        if (start_raw && tick && sup_on)
        begin
            if (sup_ms_r >= t_rel_r)
                sup_fail_nxt = 1'b1;
            else
                sup_ms_nxt = sup_ms_r + 16'h0001;
        end
        // RULE3: pulse window 20 ms to 15 s
        pls_ms_nxt = pls_s ? pls_ms_r : 16'h0000;
        if (pls_s && tick && pls_ms_r != 16'hFFFF)
            pls_ms_nxt = pls_ms_r + 16'h0001;
        // RULE4: duration fault alarms, set wins
        pls_al_nxt = pls_al_r;
        if (wr_i && addr_i == REG_ALARM && wdata_i[0])
            pls_al_nxt = 1'b0;
        if (remote_pulse_alloc_i && pls_s
            && pls_ms_r > 16'(PULSE_MAX_MS))
            pls_al_nxt = 1'b1;
        if (remote_pulse_alloc_i && !pls_s && pls_d_r
            && pls_ms_r < 16'(PULSE_MIN_MS))
            pls_al_nxt = 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sup_ms_r   <= 16'h0000;
            sup_fail_r <= 1'b0;
            pls_ms_r   <= 16'h0000;
            pls_al_r   <= 1'b0;
            pls_d_r    <= 1'b0;
        end
        else
        begin
            sup_ms_r   <= sup_ms_nxt;
            sup_fail_r <= sup_fail_nxt;
            pls_ms_r   <= pls_ms_nxt;
            pls_al_r   <= pls_al_nxt;
            pls_d_r    <= pls_s;
        end
    end

    assign sup_fail = sup_fail_r;

    // ********************************************************************
    // Two-stage breaker-failure sequencer
    // ********************************************************************
    bfpl_st_t    st_r, st_nxt;
    logic [15:0] ms_r, ms_nxt, t1, t2;
    logic        cur_ok, active, bnr_lat_r, bnr_lat_nxt, use_pls_r, use_pls_nxt;
    logic        rep_nxt, rep_r, bz_nxt, bz_r;

    assign cur_ok = cur_s || sen_s;
    assign active = start_ok || (use_pls_r && pls_ok);

    // Stage delays
    always_comb
    begin
        // RULE20: pulse delay times repetition
        t1 = use_pls_r ? t_pls_r : t_rep_r;
        // RULE14: not-ready delay substitution
        if (bnr_lat_r)
            t2 = t_cbf_r;
        else
            t2 = mp_s ? t_mp_r : t_sp_r;
    end

    always_comb
    begin
        st_nxt      = st_r;
        ms_nxt      = (tick && ms_r != 16'hFFFF) ? ms_r + 16'h0001 : ms_r;
        bnr_lat_nxt = bnr_lat_r;
        use_pls_nxt = use_pls_r;
        rep_nxt     = 1'b0;
        bz_nxt      = 1'b0;
        unique case (st_r)
            ST_IDLE:
            begin
                ms_nxt = 16'h0000;
                if (start_ok || pls_ok)
                begin
                    bnr_lat_nxt = bnr_s;
                    use_pls_nxt = pls_ok && !start_ok;
                    st_nxt = (mode_ext && start_ok) ? ST_TRIP : ST_STAGE1;
                end
            end
            ST_STAGE1:
            begin
                // RULE21: drop-out restarts timers
                if (!active || !cur_ok && !mode_unb && !lowi_r)
                    st_nxt = ST_IDLE;
                else if (ms_r >= t1)
                begin
                    st_nxt = ST_STAGE2;
                    ms_nxt = 16'h0000;
                end
            end
            ST_STAGE2:
            begin
                // RULE5: pulse feeder trip
                // RULE15: not-ready blocks repetition
                rep_nxt = (mode_rep || use_pls_r)
                          && (!bnr_lat_r || lowi_r) && cur_ok;
                if (!active || !cur_ok)
                    st_nxt = ST_IDLE;
                // RULE6: second stage after delay
                else if (ms_r >= t2)
                    st_nxt = ST_TRIP;
            end
            ST_TRIP:
            begin
                bz_nxt = 1'b1;
                if (!active)
                    st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_r      <= ST_IDLE;
            ms_r      <= 16'h0000;
            bnr_lat_r <= 1'b0;
            use_pls_r <= 1'b0;
            rep_r     <= 1'b0;
            bz_r      <= 1'b0;
        end
        else
        begin
            st_r      <= st_nxt;
            ms_r      <= ms_nxt;
            bnr_lat_r <= bnr_lat_nxt;
            use_pls_r <= use_pls_nxt;
            rep_r     <= rep_nxt;
            bz_r      <= bz_nxt;
        end
    end

    assign st_bits = st_r;

    // ********************************************************************
    // Internal supervision after busbar trip
    // ********************************************************************
    logic [15:0] bb_ms_r, bb_ms_nxt;
    logic        bb_tt_r, bb_tt_nxt, inv_r, inv_nxt, hz_r, hz_nxt;
    logic        tt_al_r, tt_al_nxt;

    always_comb
    begin
        // RULE7: supervise tripped feeder
        // RULE11: coupler bays included
        bb_ms_nxt = busbar_trip_i ? bb_ms_r : 16'h0000;
        if (busbar_trip_i && tick && bb_ms_r != 16'hFFFF)
            bb_ms_nxt = bb_ms_r + 16'h0001;
        // RULE8: transfer trip on persisting current
        // RULE10: multi-pole delay timing
        bb_tt_nxt = busbar_trip_i && cur_s && (bb_ms_r >= t_mp_r)
                    && !coupler_bay_i;
        // RULE12: coupler current unbalancing
        inv_nxt = busbar_trip_i && coupler_bay_i && cur_s
                  && (bb_ms_r >= t_mp_r) || (inv_r && busbar_trip_i);
        // RULE13: healthy zone trip
        hz_nxt = inv_r && busbar_trip_i && cur_ok;
        // RULE9: transfer trip alarms
        tt_al_nxt = tt_al_r || bb_tt_r || hz_r;
        if (wr_i && addr_i == REG_ALARM && wdata_i[1] && !bb_tt_r && !hz_r)
            tt_al_nxt = 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            bb_ms_r <= 16'h0000;
            bb_tt_r <= 1'b0;
            inv_r   <= 1'b0;
            hz_r    <= 1'b0;
            tt_al_r <= 1'b0;
        end
        else
        begin
            bb_ms_r <= bb_ms_nxt;
            bb_tt_r <= bb_tt_nxt;
            inv_r   <= inv_nxt;
            hz_r    <= hz_nxt;
            tt_al_r <= tt_al_nxt;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign alarm_r   = {2'b00, tt_al_r, pls_al_r};

    assign repeat_trip_o          = rep_r;
    assign bus_zone_trip_o        = bz_r;
    assign healthy_zone_trip_o    = hz_r;
    // RULE16: trip also transfer trips
    assign transfer_trip_o        = bz_r || bb_tt_r || hz_r;
    assign invert_polarity_o      = inv_r;
    assign pulse_duration_alarm_o = pls_al_r;
    assign pulse_duration_group_o = pls_al_r;
    assign transfer_trip_alarm_o  = tt_al_r;
    assign transfer_trip_group_o  = tt_al_r;

endmodule

// >>> bfpl_core_asserts.sv
`timescale 1ns/100ps
module bfpl_core_asserts
    import bfpl_pkg::*;
(
    input wire logic       ref_clk_i,              // Clock
    input wire logic       rst_i,                  // Reset
    input wire logic       wr_i,                   // Write strobe
    input wire logic [7:0] addr_i,                 // Address
    input wire logic       busbar_trip_i,          // Busbar trip
    input wire logic       coupler_bay_i,          // Coupler bay
    input wire logic       bus_zone_trip_o,        // Zone trip
    input wire logic       healthy_zone_trip_o,    // Other zone
    input wire logic       transfer_trip_o,        // Transfer
    input wire logic       invert_polarity_o,      // Unbalance
    input wire logic       pulse_duration_alarm_o, // Pulse alarm
    input wire logic       pulse_duration_group_o, // Group
    input wire logic       transfer_trip_alarm_o,  // Transfer alarm
    input wire logic       transfer_trip_group_o   // Group
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ****************************************
    // Trip and alarm relations
    // ****************************************
    zone_xfer_a: assert property (
        bus_zone_trip_o |-> transfer_trip_o)
        else $error("zone trip without transfer trip");
    healthy_xfer_a: assert property (
        healthy_zone_trip_o |-> transfer_trip_o)
        else $error("healthy zone trip without transfer");
    pulse_group_a: assert property (
        pulse_duration_alarm_o == pulse_duration_group_o)
        else $error("pulse alarm and group differ");
    xfer_group_a: assert property (
        transfer_trip_alarm_o == transfer_trip_group_o)
        else $error("transfer alarm and group differ");
    invert_cause_a: assert property (
        $rose(invert_polarity_o) |-> busbar_trip_i && coupler_bay_i)
        else $error("inversion without coupler busbar trip");
    healthy_cause_a: assert property (
        $rose(healthy_zone_trip_o) |-> invert_polarity_o && coupler_bay_i)
        else $error("healthy zone trip before inversion");
    bb_alarm_a: assert property (
        $rose(transfer_trip_o) && busbar_trip_i && !coupler_bay_i
        |-> ##[0:2] transfer_trip_alarm_o)
        else $error("busbar transfer without alarm");
    alarm_clear_a: assert property (
        $fell(pulse_duration_alarm_o) || $fell(transfer_trip_alarm_o)
        |-> $past(wr_i) && $past(addr_i) == REG_ALARM)
        else $error("alarm dropped without clear");

    zone_trip_c: cover property ($rose(bus_zone_trip_o));
    healthy_c:   cover property ($rose(healthy_zone_trip_o));
    pulse_al_c:  cover property ($rose(pulse_duration_alarm_o));
endmodule

bind bfpl_core bfpl_core_asserts chk_u (.*);

// >>> bfpl_remote_end.sv
`timescale 1ns/100ps
module bfpl_remote_end
(
    input  wire logic        ref_clk_i, // Clock
    input  wire logic        rst_i,     // Reset
    input  wire logic        fire_i,    // Start a pulse
    input  wire logic [19:0] len_i,     // Pulse length, cycles
    output logic             pulse_o    // Pulse to bay input
);
    logic [19:0] cnt_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            cnt_r <= 20'h0;
        else if (fire_i)
            cnt_r <= len_i;
        else if (cnt_r != 20'h0)
            cnt_r <= cnt_r - 20'h1;
    end
    assign pulse_o = (cnt_r != 20'h0);
endmodule

// >>> bfpl_core_test.sv
`timescale 1ns/100ps
module bfpl_core_test;
    import bfpl_pkg::*;
    localparam int TK = 4;
    logic        ref_clk_i, rst_i, wr_i, rd_i, fire;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [19:0] plen;
    logic        feeder_init_i, multi_pole_i, release_i, remote_pulse_i;
    logic        remote_pulse_alloc_i, breaker_not_ready_i, coupler_bay_i;
    logic        current_release_i, sens_current_i, busbar_trip_i;
    logic        repeat_trip_o, bus_zone_trip_o, healthy_zone_trip_o;
    logic        transfer_trip_o, invert_polarity_o, transfer_trip_group_o;
    logic        pulse_duration_alarm_o, pulse_duration_group_o;
    logic        transfer_trip_alarm_o;
    logic [8:0]  outs;
    int          num_errors, checks;

    assign outs = {transfer_trip_group_o, transfer_trip_alarm_o,
        pulse_duration_group_o, pulse_duration_alarm_o, invert_polarity_o,
        transfer_trip_o, healthy_zone_trip_o, bus_zone_trip_o, repeat_trip_o};

    bfpl_core #(.TICK_CYCLES(TK)) dut_u (.*);
    bfpl_remote_end far_u (.ref_clk_i, .rst_i, .fire_i(fire), .len_i(plen),
        .pulse_o(remote_pulse_i));

    // Clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic in_win(input int c, input int ms);
        return c >= 0 && c >= (ms - 2) * TK && c <= (ms + 2) * TK + 8;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask

    // First rise cycles of two outputs
    task automatic watch(input int n, ka, kb, input logic drop,
                         output int a, b);
        a = -1;
        b = -1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk_i);
            if (drop && a >= 0)
                {current_release_i, sens_current_i} <= 2'b00;
            #1;
            if (a < 0 && outs[ka] === 1'b1)
                a = i;
            if (b < 0 && outs[kb] === 1'b1)
                b = i;
        end
    endtask

    task automatic quiet;
        @(posedge ref_clk_i);
        {feeder_init_i, release_i, current_release_i, sens_current_i} <= 0;
        {busbar_trip_i, coupler_bay_i, breaker_not_ready_i} <= 0;
        repeat (16) @(posedge ref_clk_i);
        #1 check(outs[4:0], 0);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    task automatic regs;
        logic [7:0]  a[10] = '{REG_CTRL, REG_T_SP, REG_T_MP, REG_T_PLS,
            REG_T_CBF, REG_T_REP, REG_T_REL, REG_STATUS, REG_ALARM, 8'h24};
        logic [31:0] v[10] = '{32'h30, RST_T_SP, RST_T_MP, RST_T_PLS,
            RST_T_CBF, RST_T_REP, RST_T_REL, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 10; i++)
            rd(a[i], v[i]);
        wr(8'h24, 32'hFFFF);
        rd(8'h24, 32'h0);
        $display("register test done");
    endtask

    task automatic bf(input int m, input logic nr, lo, drop);
        int r, c, d, mp, ts, tm;
        ts = 6 + $urandom % 3;
        tm = 10 + $urandom % 3;
        mp = $urandom % 2;
        d = nr ? 4 : (mp != 0 ? tm : ts);
        wr(REG_CTRL, 32'(m) | 32'($urandom % 2) << 5 | 32'(lo) << 6);
        wr(REG_T_REP, 32'h2);
        wr(REG_T_SP, 32'(ts));
        wr(REG_T_MP, 32'(tm));
        wr(REG_T_CBF, 32'h4);
        @(posedge ref_clk_i);
        {multi_pole_i, breaker_not_ready_i} <= {mp[0], nr};
        {feeder_init_i, release_i, current_release_i, sens_current_i} <= 4'hF;
        watch((d + 6) * TK + 8, 0, 1, drop, r, c);
        check(in_win(r, 2), (m == 2 || m == 4) && (!nr || lo));
        check(in_win(c, m == 5 ? 0 : 2 + d), m != 0 && !drop);
        quiet;
        $display("mode %0d test done", m);
    endtask

    task automatic pulse(input int m, input int ms);
        int r, c;
        wr(REG_CTRL, 32'(m));
        wr(REG_T_PLS, 32'h3);
        wr(REG_T_SP, 32'h5);
        @(posedge ref_clk_i);
        {multi_pole_i, current_release_i, sens_current_i} <= 3'b011;
        {remote_pulse_alloc_i, fire, plen} <= {2'b11, 20'(ms * TK)};
        @(posedge ref_clk_i);
        fire <= 1'b0;
        watch((ms + 4) * TK, 0, 1, 0, r, c);
        if (ms >= 20)
        begin
            check(in_win(r, 3), m != 1);
            check(in_win(c, 8), m != 1);
        end
        check(outs[6:5], ms < 20 ? 3 : 0);
        rd(REG_ALARM, ms < 20 ? 1 : 0);
        wr(REG_ALARM, 32'h1);
        rd(REG_ALARM, 32'h0);
        quiet;
        $display("pulse test done");
    endtask

    task automatic bb(input logic cp);
        int a, b;
        wr(REG_T_MP, 32'h5);
        @(posedge ref_clk_i);
        {busbar_trip_i, coupler_bay_i} <= {1'b1, cp};
        {current_release_i, sens_current_i} <= 2'b11;
        watch(12 * TK, cp ? 4 : 3, cp ? 2 : 7, 0, a, b);
        check(in_win(a, 5), 1);
        check(b >= a && a >= 0, 1);
        rd(REG_ALARM, 32'h2);
        wr(REG_ALARM, 32'h2);
        quiet;
        $display("busbar test done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst_i, wr_i, rd_i, fire, addr_i, wdata_i, plen} = 64'h1 << 63;
        {feeder_init_i, multi_pole_i, release_i, remote_pulse_alloc_i} = 0;
        {breaker_not_ready_i, current_release_i, sens_current_i} = 0;
        {busbar_trip_i, coupler_bay_i} = 0;
        void'($urandom(7));
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        regs;
        for (int m = 0; m < 6; m++)
            bf(m, 0, 0, 0);
        bf(2, 1, 0, 0);
        bf(4, 1, 1, 0);
        bf(2, 0, 0, 1);
        pulse(1, 30);
        pulse(2, 30);
        pulse(4, 5);
        bb(0);
        bb(1);
        tally_and_finish;
    end

    // Watchdog
    initial
    begin
        #(40 * 50000);
        num_errors++;
        tally_and_finish;
    end
endmodule
